/* draw_target_msaa.sv */
// Purpose: draw target selection, command checking and per-sample msaa ops
// Assumes: fragment port on aclk, registers over AXI4-Lite
// Notes:   one fragment per cycle, results one cycle after acceptance
//
// How it works
// - logic op write with low five code bits 16 or above flags invalid value, keeps mode.
// - color zero target NONE leaves all sample and color buffers untouched.
// - multisample on with sample buffer runs every step per sample.
// - failed alpha, stencil or depth test ends only that sample.
// - uncovered samples get no stencil, depth or color update.
// - per-sample writes go to multisample storage, not single-sample buffers.
// - multisample off with sample buffer means full coverage, centre shortcut allowed.
// - shortcut writes stencil to every sample regardless of stencil result.
// - shortcut depth pass writes all depth and color samples, fail writes none.
// - no object bound: samples resolve to one color sent to selected buffers.
// - resolve is issued per fragment, so visible state matches per-fragment update.
// - resolve uses plain per-component average of samples.
// - unnamed commands hit the bound framebuffer, named ones the given name.
// - default framebuffer group selectors map to front/back left/right subsets.
// - auxiliary selector is base plus index below the auxiliary count.
// - attachment selector routes color only to attachment point i.
// - missing default buffer or attachment index over limit flags invalid operation.
// - named command with nonexistent nonzero object flags invalid operation.
// - single-target command sets all colors other than zero to NONE.
// - multi-target list fills colors in order, rest become NONE.
// - broadcast color goes to every target, indexed colors to their own.
// - maximum draw target count is readable.
// - reset targets: default BACK or FRONT, objects attachment zero, others NONE.
// - attachment without image drops that color's resolved write; the sample write for it is still issued.
//
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
module draw_target_msaa
   import draw_target_pkg::*;
#(
   parameter int NUM_FB       = 4,
   parameter int AUX_CNT      = 4,
   parameter int MAX_ATT      = 8,
   parameter int BACK_PRESENT = 1,
   parameter int STEREO       = 0,
   parameter int CENTER       = 0
) (
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   input  wire logic                      ce,
   input  wire logic                      awvalid,
   output      logic                      awready,
   input  wire logic [7:0]                awaddr,
   input  wire logic                      wvalid,
   output      logic                      wready,
   input  wire logic [31:0]               wdata,
   input  wire logic [3:0]                wstrb,
   output      logic                      bvalid,
   input  wire logic                      bready,
   output      logic [1:0]                bresp,
   input  wire logic                      arvalid,
   output      logic                      arready,
   input  wire logic [7:0]                araddr,
   output      logic                      rvalid,
   input  wire logic                      rready,
   output      logic [31:0]               rdata,
   output      logic [1:0]                rresp,
   input  wire logic                      frag_valid,
   output      logic                      frag_ready,
   input  wire draw_target_pkg::frag_t    frag,
   output      logic                      samp_valid,
   output      draw_target_pkg::samp_wr_t samp_wr,
   output      logic                      res_valid,
   output      draw_target_pkg::resolve_t res,
   output      logic [3:0]                logic_op
);
   import draw_target_pkg::*;

   localparam int FBW = (NUM_FB > 1) ? $clog2(NUM_FB) : 1;
   localparam int SH  = $clog2(NS);
   localparam logic [3:0] PRESENT = {(STEREO != 0 && BACK_PRESENT != 0),
                                     (BACK_PRESENT != 0), (STEREO != 0), 1'b1};

   logic [31:0]          ctrl_reg;
   logic [3:0]           lop_reg;
   logic [15:0]          fex_reg;
   logic [7:0]           img_reg;
   logic [2:0]           err_reg;
   logic [CW-1:0]        list_reg [NC];
   logic [CW-1:0]        tgt_reg  [NUM_FB][NC];
   logic                 aw_have_reg;
   logic                 w_have_reg;
   logic [7:0]           aw_addr_reg;
   logic [31:0]          wdata_reg;
   logic [3:0]           wstrb_reg;
   logic                 bvalid_reg;
   logic [1:0]           bresp_reg;
   logic                 rvalid_reg;
   logic [31:0]          rdata_reg;
   logic [1:0]           rresp_reg;
   logic                 wr_go;
   logic [31:0]          wd;
   logic [32:0]          wr_look;
   logic [32:0]          rd_look;
   logic [3:0]           bfb;
   logic [FBW-1:0]       bidx;
   logic [2:0]           err_set;
   logic [2:0]           err_clr;

   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   function automatic logic [3:0] dmask(input logic [CW-1:0] c);
      unique case (c)
         T_FL:    dmask = 4'h1;
         T_FR:    dmask = 4'h2;
         T_BL:    dmask = 4'h4;
         T_BR:    dmask = 4'h8;
         T_FRONT: dmask = 4'h3;
         T_BACK:  dmask = 4'hc;
         T_LEFT:  dmask = 4'h5;
         T_RIGHT: dmask = 4'ha;
         T_FAB:   dmask = 4'hf;
         default: dmask = 4'h0;
      endcase
   endfunction : dmask

   function automatic logic [2:0] chk(input logic [CW-1:0] c, input logic fbo,
                                      input logic multi, input logic [3:0] n);
      chk = 3'h0;
      if (c == T_NONE) begin
         chk = 3'h0;
      end else if (c[5:4] == 2'b10) begin
         if (!fbo || 32'(c[4:0]) >= MAX_ATT) chk[E_OP] = 1'b1;
      end else if (c[5:4] == 2'b01) begin
         if (fbo || 32'(c[3:0]) >= AUX_CNT) chk[E_OP] = 1'b1;
      end else if (dmask(c) != 4'h0) begin
         if (fbo) begin
            chk[E_OP] = 1'b1;
         end else if (multi && (c == T_FRONT || c == T_LEFT || c == T_RIGHT
                                || c == T_FAB)) begin
            chk[E_ENUM] = 1'b1;
         end else if (multi && c == T_BACK) begin
            if (n != 4'd1) chk[E_OP] = 1'b1;
         end else if ((dmask(c) & PRESENT) == 4'h0) begin
            chk[E_OP] = 1'b1;
         end
      end else begin
         chk[E_ENUM] = 1'b1;
      end
   endfunction : chk

   function automatic logic [MW-1:0] tdest(input logic [CW-1:0] c, input logic fbo,
                                           input logic [7:0] img);
      tdest = '0;
      if (c[5:4] == 2'b10) begin
         if (fbo && 32'(c[4:0]) < MAX_ATT) tdest[MB_ATT + 32'(c[2:0])] = img[c[2:0]];
      end else if (c[5:4] == 2'b01) begin
         if (!fbo && 32'(c[3:0]) < AUX_CNT) tdest[MB_AUX + 32'(c[1:0])] = 1'b1;
      end else if (!fbo) begin
         tdest[3:0] = dmask(c) & PRESENT;
      end
   endfunction : tdest

   function automatic logic [32:0] rmux(input logic [7:0] a);
      rmux = {1'b1, 32'h0};
      if (a == A_CTRL) rmux[31:0] = ctrl_reg;
      else if (a == A_LOP) rmux[3:0] = lop_reg;
      else if (a == A_FEX) rmux[15:0] = fex_reg;
      else if (a == A_IMG) rmux[7:0] = img_reg;
      else if (a == A_ERR) rmux[2:0] = err_reg;
      else if (a == A_MAXD) rmux[31:0] = 32'(NC);
      else if (a == A_CMD) rmux[31:0] = 32'h0;
      else if (a >= A_LIST && a < A_LIST + 8'(4 * NC) && a[1:0] == 2'b00)
         rmux[CW-1:0] = list_reg[a[SH+1:2]];
      else if (a >= A_TGT && a < A_TGT + 8'(4 * NC) && a[1:0] == 2'b00)
         rmux[CW-1:0] = tgt_reg[bidx][a[SH+1:2]];
      else rmux[32] = 1'b0;
   endfunction : rmux

   // ----------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------
   assign awready = ce & ~aw_have_reg;
   assign wready  = ce & ~w_have_reg;
   assign arready = ce & ~rvalid_reg;
   assign bvalid  = bvalid_reg;
   assign bresp   = bresp_reg;
   assign rvalid  = rvalid_reg;
   assign rdata   = rdata_reg;
   assign rresp   = rresp_reg;
   assign wr_go   = aw_have_reg & w_have_reg & ~bvalid_reg;
   always_comb wr_look = rmux(aw_addr_reg);
   always_comb rd_look = rmux(araddr);

   always_comb begin
      for (int k = 0; k < 4; k++)
         wd[8*k +: 8] = wstrb_reg[k] ? wdata_reg[8*k +: 8] : wr_look[8*k +: 8];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg <= 1'b0;
         w_have_reg  <= 1'b0;
         aw_addr_reg <= 8'h00;
         wdata_reg   <= 32'h0;
         wstrb_reg   <= 4'h0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OK;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= 32'h0;
         rresp_reg   <= RESP_OK;
      end else if (ce) begin
         if (awvalid && awready) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= awaddr;
         end
         if (wvalid && wready) begin
            w_have_reg <= 1'b1;
            wdata_reg  <= wdata;
            wstrb_reg  <= wstrb;
         end
         if (wr_go) begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            bvalid_reg  <= 1'b1;
            bresp_reg   <= wr_look[32] ? RESP_OK : RESP_ERR;
         end else if (bvalid_reg && bready) begin
            bvalid_reg <= 1'b0;
         end
         if (arvalid && arready) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_look[31:0];
            rresp_reg  <= rd_look[32] ? RESP_OK : RESP_ERR;
         end else if (rvalid_reg && rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // command check
   // ----------------------------------------
   logic          c_multi;
   logic [3:0]    c_fb;
   logic [3:0]    c_cnt;
   logic [2:0]    c_err;
   logic [CW-1:0] new_t [NC];

   assign bfb  = ctrl_reg[CTRL_FB +: 4];
   assign bidx = (32'(bfb) < NUM_FB) ? FBW'(bfb) : '0;

   always_comb begin
      c_multi = wdata_reg[CMD_MULTI];
      c_fb    = wdata_reg[CMD_NAMED] ? wdata_reg[CMD_NAME +: 4] : 4'(bidx);
      c_cnt   = c_multi ? wdata_reg[CMD_N +: 4] : 4'd1;
      c_err   = 3'h0;
      if (c_fb != 4'h0 && (32'(c_fb) >= NUM_FB || !fex_reg[c_fb])) c_err[E_OP] = 1'b1;
      if (c_multi && 32'(c_cnt) > NC) c_err[E_VALUE] = 1'b1;
      for (int i = 0; i < NC; i++) begin
         new_t[i] = T_NONE;
         if (i < 32'(c_cnt)) begin
            c_err = c_err | chk(list_reg[i], c_fb != 4'h0, c_multi, c_cnt);
            if (c_multi && list_reg[i] == T_BACK)
               new_t[i] = (BACK_PRESENT != 0) ? T_BL : T_FL;
            else
               new_t[i] = list_reg[i];
            for (int j = 0; j < i; j++)
               if (list_reg[i] != T_NONE && list_reg[i] == list_reg[j])
                  c_err[E_OP] = 1'b1;
         end
      end
   end

   // ----------------------------------------
   // control registers and targets
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= RST_CTRL;
         lop_reg  <= RST_LOP;
         fex_reg  <= RST_FEX;
         img_reg  <= RST_IMG;
         for (int i = 0; i < NC; i++) list_reg[i] <= T_NONE;
      end else if (ce && wr_go) begin
         if (aw_addr_reg == A_CTRL) ctrl_reg <= wd;
         if (aw_addr_reg == A_LOP && 32'(wd[4:0]) < LOP_MODES) lop_reg <= wd[3:0];
         if (aw_addr_reg == A_FEX) fex_reg <= wd[15:0];
         if (aw_addr_reg == A_IMG) img_reg <= wd[7:0];
         for (int i = 0; i < NC; i++)
            if (aw_addr_reg == A_LIST + 8'(4 * i)) list_reg[i] <= wd[CW-1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int f = 0; f < NUM_FB; f++)
            for (int i = 0; i < NC; i++)
               tgt_reg[f][i] <= (i != 0) ? T_NONE : (f != 0) ? T_ATT0 :
                                (BACK_PRESENT != 0) ? T_BACK : T_FRONT;
      end else if (ce && wr_go && aw_addr_reg == A_CMD && c_err == 3'h0) begin
         for (int i = 0; i < NC; i++) tgt_reg[FBW'(c_fb)][i] <= new_t[i];
      end
   end

   // errors stick; a new error in the clearing cycle survives
   always_comb begin
      err_set = 3'h0;
      err_clr = 3'h0;
      if (wr_go && aw_addr_reg == A_CMD) err_set = c_err;
      if (wr_go && aw_addr_reg == A_LOP && 32'(wd[4:0]) >= LOP_MODES)
         err_set[E_VALUE] = 1'b1;
      if (wr_go && aw_addr_reg == A_ERR) err_clr = wd[2:0];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) err_reg <= 3'h0;
      else if (ce) err_reg <= (err_reg & ~err_clr) | err_set;
   end

   assign logic_op = lop_reg;

   // ----------------------------------------
   // per-sample operations and resolve
   // ----------------------------------------
   logic          fbo;
   logic          none0;
   logic          cpass;
   logic [NS-1:0] cov;
   logic [NS-1:0] rwe;
   samp_wr_t      sw;
   resolve_t      rs;

   assign frag_ready = ce;

   always_comb begin
      fbo   = bidx != '0;
      none0 = tgt_reg[bidx][0] == T_NONE;
      cov   = ctrl_reg[CTRL_MS] ? frag.cov : '1;
      cpass = frag.alpha_ok[CENTER] & frag.stencil_ok[CENTER] & frag.depth_ok[CENTER];
      sw    = '0;
      sw.color = frag.color[0];
      if (ctrl_reg[CTRL_SB] && !none0) begin
         if (!ctrl_reg[CTRL_MS] && ctrl_reg[CTRL_SC]) begin
            sw.stencil_we = {NS{frag.alpha_ok[CENTER]}};
            sw.depth_we   = {NS{cpass}};
            sw.color_we   = {NS{cpass}};
            sw.depth_from_center = 1'b1;
         end else begin
            sw.stencil_we = cov & frag.alpha_ok;
            sw.depth_we   = cov & frag.alpha_ok & frag.stencil_ok & frag.depth_ok;
            sw.color_we   = sw.depth_we;
         end
      end
      rwe = ctrl_reg[CTRL_SB] ? sw.color_we : {NS{cpass & ~none0}};
      for (int i = 0; i < NC; i++) begin
         for (int k = 0; k < 4; k++) begin
            logic [7+SH:0] sum;
            sum = '0;
            for (int s = 0; s < NS; s++)
               sum = sum + (8+SH)'(rwe[s] ? (frag.bcast ? frag.color[0][8*k +: 8]
                                               : frag.color[i][8*k +: 8])
                                           : frag.dest[i][s][8*k +: 8]);
            rs.color[i][8*k +: 8] = sum[7+SH:SH];
         end
         rs.dest[i] = tdest(tgt_reg[bidx][i], fbo, img_reg);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         samp_valid <= 1'b0;
         samp_wr    <= '0;
         res_valid  <= 1'b0;
         res        <= '0;
      end else if (ce) begin
         samp_valid <= frag_valid & ctrl_reg[CTRL_SB] & ~none0;
         samp_wr    <= sw;
         res_valid  <= frag_valid & ~none0 & (~ctrl_reg[CTRL_SB] | ~fbo);
         res        <= rs;
      end
   end
endmodule : draw_target_msaa

/* draw_target_msaa_sva.sv */
// Purpose: port checks for draw_target_msaa
// Assumes: one clock, sync active-low reset, ce low freezes all flops
// Notes:   bind statement follows the module
`timescale 1ns/10ps
module draw_target_msaa_sva (
   input wire logic                      aclk,
   input wire logic                      aresetn,
   input wire logic                      ce,
   input wire logic                      awready,
   input wire logic                      wready,
   input wire logic                      arvalid,
   input wire logic                      arready,
   input wire logic                      bvalid,
   input wire logic                      bready,
   input wire logic [1:0]                bresp,
   input wire logic                      rvalid,
   input wire logic                      frag_valid,
   input wire logic                      frag_ready,
   input wire draw_target_pkg::frag_t    frag,
   input wire logic                      samp_valid,
   input wire draw_target_pkg::samp_wr_t samp_wr,
   input wire logic                      res_valid,
   input wire logic [3:0]                logic_op
);
   import draw_target_pkg::*;
   default clocking dc @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_ar_take;
      arvalid && arready;
   endsequence
   sequence s_frag_take;
      frag_valid && frag_ready;
   endsequence
   // mode moves only with a completed write; the written code itself is not compared
   a_lop_write_only: assert property (!$stable(logic_op) |-> $rose(bvalid))
      else $error("logic op moved outside a write");
   a_frag_answer: assert property ((samp_valid || res_valid) && $past(ce)
      |-> $past(frag_valid && frag_ready))
      else $error("fragment result without a taken fragment");
   a_we_pair: assert property (samp_valid |-> samp_wr.color_we == samp_wr.depth_we)
      else $error("color and depth sample writes differ");
   a_stencil_cover: assert property (samp_valid
      |-> (samp_wr.color_we & ~samp_wr.stencil_we) == 4'h0)
      else $error("color written where stencil is not");
   a_samp_color: assert property (s_frag_take ##1 samp_valid
      |-> samp_wr.color == $past(frag.color[0]))
      else $error("sample color is not fragment color zero");
   a_b_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped early");
   a_ready_ce: assert property (!ce |-> !(awready || wready || arready || frag_ready))
      else $error("ready while clock enable low");
   a_read_answer: assert property (s_ar_take |=> rvalid)
      else $error("read data late");
endmodule : draw_target_msaa_sva

bind draw_target_msaa draw_target_msaa_sva i_sva (.aclk, .aresetn, .ce, .awready, .wready,
   .arvalid, .arready, .bvalid, .bready, .bresp, .rvalid, .frag_valid, .frag_ready, .frag,
   .samp_valid, .samp_wr, .res_valid, .logic_op);

/* draw_target_msaa_tb.sv */
// Purpose: directed bench over AXI4-Lite and the fragment port
// Assumes: mono, back buffer present, four aux buffers
// Notes:   expectations are hand-worked literals and package constants
`timescale 1ns/10ps
module draw_target_msaa_tb;
   import draw_target_pkg::*;
   localparam int AUX_N = 4;
   logic        aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, frag_valid, frag_ready, samp_valid, res_valid;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd_q;
   logic [3:0]  wstrb, logic_op;
   logic [1:0]  bresp, rresp, rsp;
   frag_t       frag;
   samp_wr_t    samp_wr;
   resolve_t    res;
   logic [MW-1:0][31:0] buf_color;
   int          wr_count, wc_q;
   int          err_total = 0;
   int          num_checks = 0;
   int          cyc = 0;
   wire logic [31:0] sw = {19'h0, samp_valid, samp_wr.stencil_we, samp_wr.depth_we,
                           samp_wr.color_we};
   wire logic [31:0] rw = {15'h0, res_valid, res.dest[0]};

   draw_target_msaa #(.AUX_CNT(AUX_N)) i_dut (.aclk, .aresetn, .ce, .awvalid, .awready,
      .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
      .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .frag_valid, .frag_ready, .frag,
      .samp_valid, .samp_wr, .res_valid, .res, .logic_op);
   fb_store_model i_store (.aclk, .aresetn, .res_valid, .res, .buf_color, .wr_count);

   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic stop_test();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (awvalid || wvalid);
      @(posedge aclk);
      bready <= 1'b1;
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(posedge aclk); while (!rvalid);
      rd_q = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask : rd
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(rd_q, e);
   endtask : rdc
   // flags are write-one-to-clear
   task automatic errc(input logic [31:0] e);
      rdc(A_ERR, e);
      wr(A_ERR, 32'h7);
   endtask : errc
   task automatic cmd(input logic [5:0] l0, input logic [5:0] l1, input logic [31:0] c);
      wr(A_LIST, {26'h0, l0});
      wr(A_LIST + 8'h4, {26'h0, l1});
      wr(A_CMD, c);
   endtask : cmd
   task automatic tgt_chk(input logic [3:0][5:0] e);
      for (int i = 0; i < 4; i++) rdc(A_TGT + 8'(4 * i), {26'h0, e[i]});
   endtask : tgt_chk
   function automatic frag_t mkf(input logic [3:0] cv, input logic [3:0] so,
                                 input logic [3:0] dp);
      mkf = '0;
      mkf.color[0] = 32'h4040_4040;
      mkf.cov = cv;
      mkf.alpha_ok = 4'hf;
      mkf.stencil_ok = so;
      mkf.depth_ok = dp;
   endfunction : mkf
   task automatic send(input frag_t f);
      frag <= f;
      frag_valid <= 1'b1;
      @(posedge aclk);
      frag_valid <= 1'b0;
      @(posedge aclk);
   endtask : send

   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         stop_test();
      end
   end

   initial begin
      aresetn = 1'b0;
      ce = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready, frag_valid} = 6'h0;
      {awaddr, araddr, wdata} = 48'h0;
      wstrb = 4'hf;
      frag = '0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      tgt_chk({T_NONE, T_NONE, T_NONE, T_BACK});
      rdc(A_MAXD, 32'h4);
      rdc(A_LOP, 32'h3);
      wr(A_LOP, 32'h5);
      wr(A_LOP, 32'h10);
      chk({28'h0, logic_op}, 32'h5);
      errc(32'h2);
      rd(8'h3c);
      chk({30'h0, rsp}, {30'h0, RESP_ERR});
      cmd(T_BL, T_AUX0 + 6'h3, 32'h21);
      tgt_chk({T_NONE, T_NONE, T_AUX0 + 6'h3, T_BL});
      cmd(T_FL, T_FL, 32'h21);
      errc(32'h4);
      cmd(T_BACK, T_FL, 32'h21);
      errc(32'h4);
      cmd(T_FR, T_NONE, 32'h10);
      errc(32'h4);
      cmd(T_AUX0 + 6'(AUX_N), T_NONE, 32'h10);
      errc(32'h4);
      tgt_chk({T_NONE, T_NONE, T_AUX0 + 6'h3, T_BL});
      cmd(T_LEFT, T_FL, 32'h10);
      tgt_chk({T_NONE, T_NONE, T_NONE, T_LEFT});
      cmd(T_FL, T_BL, 32'h21);
      cmd(T_BACK, T_FL, 32'h11);
      tgt_chk({T_NONE, T_NONE, T_NONE, T_BL});
      cmd(T_LEFT, T_NONE, 32'h10);
      send(mkf(4'hf, 4'hf, 4'hf));
      chk(rw, 32'h1_0005);
      chk(sw, 32'h0);
      wr(A_CTRL, 32'h3);
      chk(buf_color[2], 32'h4040_4040);
      send(mkf(4'h5, 4'hf, 4'hf));
      chk(sw, 32'h1555);
      chk(res.color[0], 32'h2020_2020);
      send(mkf(4'hf, 4'hf, 4'he));
      chk(sw, 32'h1fee);
      wr(A_CTRL, 32'h6);
      send(mkf(4'h0, 4'hf, 4'hf));
      chk(sw, 32'h1fff);
      send(mkf(4'h0, 4'he, 4'hf));
      chk(sw, 32'h1f00);
      send(mkf(4'h0, 4'hf, 4'he));
      chk(sw, 32'h1f00);
      cmd(T_NONE, T_NONE, 32'h10);
      wc_q = wr_count;
      send(mkf(4'hf, 4'hf, 4'hf));
      chk({30'h0, samp_valid, res_valid}, 32'h0);
      wr(A_CTRL, 32'h0);
      chk(wr_count, wc_q);
      cmd(T_ATT0 + 6'h1, T_NONE, 32'h0212);
      errc(32'h4);
      wr(A_FEX, 32'h6);
      cmd(T_ATT0 + 6'h8, T_NONE, 32'h0212);
      errc(32'h4);
      cmd(T_ATT0 + 6'h1, T_NONE, 32'h0213);
      wr(A_CTRL, 32'h100);
      tgt_chk({T_NONE, T_NONE, T_NONE, T_ATT0});
      wr(A_CTRL, 32'h200);
      tgt_chk({T_NONE, T_NONE, T_NONE, T_ATT0 + 6'h1});
      send(mkf(4'hf, 4'hf, 4'hf));
      chk(rw & 32'hffff, 32'h0);
      wr(A_IMG, 32'h3);
      send(mkf(4'hf, 4'hf, 4'hf));
      chk(rw, 32'h1_0200);
      ce <= 1'b0;
      @(posedge aclk);
      ce <= 1'b1;
      @(posedge aclk);
      stop_test();
   end
endmodule : draw_target_msaa_tb

/* draw_target_pkg.sv */
// Purpose: shared constants and carriers for draw target select and msaa ops
// Assumes: aclk at 125 MHz, AXI4-Lite register access
// Notes:   target codes are 6 bits: groups below 6'h10, aux 6'h1x, attach 6'h2x
package draw_target_pkg;
   localparam int NC = 4;
   localparam int NS = 4;
   localparam int CW = 6;
   localparam int MW = 16;
   localparam int DW = 32;
   localparam int LOP_MODES = 16;

   // ----------------------------------------
   // target codes
   // ----------------------------------------
   localparam logic [CW-1:0] T_NONE  = 6'h00;
   localparam logic [CW-1:0] T_FL    = 6'h01;
   localparam logic [CW-1:0] T_FR    = 6'h02;
   localparam logic [CW-1:0] T_BL    = 6'h03;
   localparam logic [CW-1:0] T_BR    = 6'h04;
   localparam logic [CW-1:0] T_FRONT = 6'h05;
   localparam logic [CW-1:0] T_BACK  = 6'h06;
   localparam logic [CW-1:0] T_LEFT  = 6'h07;
   localparam logic [CW-1:0] T_RIGHT = 6'h08;
   localparam logic [CW-1:0] T_FAB   = 6'h09;
   localparam logic [CW-1:0] T_AUX0  = 6'h10;
   localparam logic [CW-1:0] T_ATT0  = 6'h20;

   // ----------------------------------------
   // register map and fields
   // ----------------------------------------
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_LOP  = 8'h04;
   localparam logic [7:0] A_FEX  = 8'h08;
   localparam logic [7:0] A_IMG  = 8'h0c;
   localparam logic [7:0] A_CMD  = 8'h10;
   localparam logic [7:0] A_ERR  = 8'h14;
   localparam logic [7:0] A_MAXD = 8'h18;
   localparam logic [7:0] A_LIST = 8'h20;
   localparam logic [7:0] A_TGT  = 8'h40;
   localparam int CTRL_MS = 0;
   localparam int CTRL_SB = 1;
   localparam int CTRL_SC = 2;
   localparam int CTRL_FB = 8;
   localparam int CMD_MULTI = 0;
   localparam int CMD_NAMED = 1;
   localparam int CMD_N     = 4;
   localparam int CMD_NAME  = 8;
   localparam int E_ENUM  = 0;
   localparam int E_VALUE = 1;
   localparam int E_OP    = 2;
   localparam int MB_AUX = 4;
   localparam int MB_ATT = 8;
   localparam logic [31:0] RST_CTRL = 32'h0000_0000;
   localparam logic [3:0]  RST_LOP  = 4'h3;
   localparam logic [15:0] RST_FEX  = 16'h0000;
   localparam logic [7:0]  RST_IMG  = 8'h01;
   localparam logic [1:0]  RESP_OK  = 2'b00;
   localparam logic [1:0]  RESP_ERR = 2'b10;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic [NC-1:0][DW-1:0]         color;
      logic                          bcast;
      logic [NS-1:0]                 cov;
      logic [NS-1:0]                 alpha_ok;
      logic [NS-1:0]                 stencil_ok;
      logic [NS-1:0]                 depth_ok;
      logic [NC-1:0][NS-1:0][DW-1:0] dest;
   } frag_t;

   typedef struct packed {
      logic [NS-1:0] color_we;
      logic [NS-1:0] depth_we;
      logic [NS-1:0] stencil_we;
      logic [DW-1:0] color;
      logic          depth_from_center;
   } samp_wr_t;

   typedef struct packed {
      logic [NC-1:0][DW-1:0] color;
      logic [NC-1:0][MW-1:0] dest;
   } resolve_t;
endpackage : draw_target_pkg

/* fb_store_model.sv */
// Purpose: framebuffer storage fed by resolved color writes
// Assumes: dest mask bit b selects storage slot b
// Notes:   last write wins; overlapping masks are undefined anyway
`timescale 1ns/10ps
module fb_store_model (
   input  wire logic                                aclk,
   input  wire logic                                aresetn,
   input  wire logic                                res_valid,
   input  wire draw_target_pkg::resolve_t           res,
   output      logic [draw_target_pkg::MW-1:0][31:0] buf_color,
   output      int                                  wr_count
);
   import draw_target_pkg::*;
   // ----------------------------------------
   // storage
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_count <= 0;
         buf_color <= '0;
      end else if (res_valid) begin
         wr_count <= wr_count + 1;
         for (int c = 0; c < NC; c++) begin
            for (int b = 0; b < MW; b++) begin
               if (res.dest[c][b]) buf_color[b] <= res.color[c];
            end
         end
      end
   end
endmodule : fb_store_model
